//--- core/dmawc_defs.svh
// Constants for the DMA mode and wait control block.
// Assumes inclusion by bare name from the core/ folder.
`ifndef DMAWC_DEFS_SVH
`define DMAWC_DEFS_SVH

// ----------------------------------------
// I/O register addresses
// ----------------------------------------
`define DMAWC_ADDR_CH0_MODE 8'h31
`define DMAWC_ADDR_WAIT_CTRL 8'h32

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DMAWC_DST_MODE_HI 5
`define DMAWC_DST_MODE_LO 4
`define DMAWC_SRC_MODE_HI 3
`define DMAWC_SRC_MODE_LO 2
`define DMAWC_BURST_SELECT 1
`define DMAWC_MEM_WAIT_HI 7
`define DMAWC_MEM_WAIT_LO 6
`define DMAWC_IO_WAIT_HI 5
`define DMAWC_IO_WAIT_LO 4
`define DMAWC_CH0_REQ_EDGE 3
`define DMAWC_CH1_REQ_EDGE 2
`define DMAWC_CH1_MODE_HI 1
`define DMAWC_CH1_MODE_LO 0
`define DMAWC_BANK_SEL_HI 17
`define DMAWC_BANK_SEL_LO 16

// ----------------------------------------
// Reset values and read masks
// ----------------------------------------
`define DMAWC_CH0_MODE_RST 8'h00
`define DMAWC_WAIT_CTRL_RST 8'hF0
`define DMAWC_CH0_MODE_MASK 8'h3E

// ----------------------------------------
// Address modes and request sources
// ----------------------------------------
`define DMAWC_AM_INC 2'h0
`define DMAWC_AM_DEC 2'h1
`define DMAWC_AM_FIX 2'h2
`define DMAWC_AM_IO 2'h3
`define DMAWC_RQ_EXT 2'h0
`define DMAWC_RQ_SER0 2'h1
`define DMAWC_RQ_SER1 2'h2

// ----------------------------------------
// Cycle timing in clocks
// ----------------------------------------
`define DMAWC_MEM_BASE_CLKS 4'h3
`define DMAWC_IO_BASE_CLKS 4'h3
`define DMAWC_IO_WAIT_MIN 3'h1
`define DMAWC_STEAL_CLKS 4'h3

`endif

//--- core/dmawc_pkg.sv
// Types for the DMA mode and wait control block.
// Assumes nothing beyond a SystemVerilog compiler.
package dmawc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_REQ,
    ST_READ,
    ST_WRITE,
    ST_STEAL
  } dmawc_state_t;

endpackage

//--- core/dmawc_fifo.sv
// Byte buffer between the read and write phases of a transfer.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module dmawc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] fill_ff;
  logic push;
  logic pop;

  assign in_ready = (fill_ff != (AW+1)'(DEPTH));
  assign out_valid = (fill_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      fill_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      if (push && !pop) begin
        fill_ff <= fill_ff + 1'b1;
      end else if (pop && !push) begin
        fill_ff <= fill_ff - 1'b1;
      end
    end
  end
endmodule

//--- core/dmawc_top.sv
// Mode registers, request pacing and wait-state timing for a two-channel DMA engine.
// Assumes a peripheral I/O register port and a system bus that grants when BUS_HOLD is high.
//
// Contract
// - Channel 0 destination mode in bits 5:4 picks memory inc, dec, fixed or I/O fixed.
// - Channel 0 source mode in bits 3:2 uses the same four codes.
// - A fixed or I/O destination paired with a fixed or I/O source is refused.
// - Bit 1 picks burst when set and cycle steal when clear, cleared at reset.
// - Burst keeps the bus until the byte count reaches zero.
// - Cycle steal hands the CPU one bus cycle after each byte.
// - With an I/O end on channel 0 the request line paces bytes and bit 1 is ignored.
// - Memory wait code adds 0 to 3 waits to every memory cycle, reset value 3.
// - I/O wait code adds 1 to 4 waits to every I/O cycle, reset value 3.
// - I/O waits stack on a three-clock base cycle.
// - Request sense bits 3 and 2 pick level (0) or edge (1) for channels 0 and 1.
// - Channel 1 mode bits 1:0 pick direction and memory step with the I/O address fixed.
// - Each byte is a source read followed by a destination write.
// - For an I/O destination, bank bits 17:16 choose the channel 0 request source.
`timescale 1ns/100ps
`include "dmawc_defs.svh"
module dmawc_top
  import dmawc_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int COUNT_W = 16,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // I/O register port
  input wire logic [7:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  // Transfer start
  input wire logic START,
  input wire logic START_CH,
  input wire logic [ADDR_W-1:0] START_SRC,
  input wire logic [ADDR_W-1:0] START_DST,
  input wire logic [COUNT_W-1:0] START_COUNT,
  // Request lines
  input wire logic EXT_REQUEST_CH0,
  input wire logic SERIAL0_TX_REQUEST,
  input wire logic SERIAL1_TX_REQUEST,
  input wire logic EXT_REQUEST_CH1,
  // System bus
  output logic BUS_HOLD,
  output logic CYC_ACTIVE,
  output logic CYC_WRITE,
  output logic CYC_IO,
  output logic [ADDR_W-1:0] CYC_ADDR,
  output logic [7:0] CYC_WDATA,
  output logic CYC_DONE,
  input wire logic BUS_READY,
  input wire logic [7:0] RD_DATA,
  // Status and CPU wait timing
  output logic BUSY,
  output logic MODE_ERR,
  output logic [COUNT_W-1:0] BYTES_LEFT,
  output logic [1:0] MEM_WAIT_STATES,
  output logic [2:0] IO_WAIT_STATES
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ch0_mode_ff;
  logic [7:0] wait_ctrl_ff;
  logic [7:0] rdata_ff;
  logic err_ff;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ch0_mode_ff <= `DMAWC_CH0_MODE_RST;
      wait_ctrl_ff <= `DMAWC_WAIT_CTRL_RST;
    end else if (IO_WR) begin
      if (IO_ADDR == `DMAWC_ADDR_CH0_MODE) begin
        ch0_mode_ff <= IO_WDATA & `DMAWC_CH0_MODE_MASK;
      end
      if (IO_ADDR == `DMAWC_ADDR_WAIT_CTRL) begin
        wait_ctrl_ff <= IO_WDATA;
      end
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 8'h00;
    end else if (IO_RD) begin
      case (IO_ADDR)
        `DMAWC_ADDR_CH0_MODE: rdata_ff <= ch0_mode_ff;
        `DMAWC_ADDR_WAIT_CTRL: rdata_ff <= wait_ctrl_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end
  assign IO_RDATA = rdata_ff;

  logic [1:0] mem_waits;
  logic [2:0] io_waits;
  logic ch0_edge;
  logic ch1_edge;
  logic [1:0] c0_dst;
  logic [1:0] c0_src;
  assign mem_waits = wait_ctrl_ff[`DMAWC_MEM_WAIT_HI:`DMAWC_MEM_WAIT_LO];
  assign io_waits = 3'(wait_ctrl_ff[`DMAWC_IO_WAIT_HI:`DMAWC_IO_WAIT_LO]) +
    `DMAWC_IO_WAIT_MIN;
  assign ch0_edge = wait_ctrl_ff[`DMAWC_CH0_REQ_EDGE];
  assign ch1_edge = wait_ctrl_ff[`DMAWC_CH1_REQ_EDGE];
  assign c0_dst = ch0_mode_ff[`DMAWC_DST_MODE_HI:`DMAWC_DST_MODE_LO];
  assign c0_src = ch0_mode_ff[`DMAWC_SRC_MODE_HI:`DMAWC_SRC_MODE_LO];

  // Registered so the CPU bus sees a stable count per cycle
  logic [1:0] mem_ws_ff;
  logic [2:0] io_ws_ff;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mem_ws_ff <= 2'h3;
      io_ws_ff <= 3'h4;
    end else begin
      mem_ws_ff <= mem_waits;
      io_ws_ff <= io_waits;
    end
  end
  assign MEM_WAIT_STATES = mem_ws_ff;
  assign IO_WAIT_STATES = io_ws_ff;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] cyc_last(input logic io, input logic [1:0] mw,
                                          input logic [2:0] iw);
    if (io) begin
      cyc_last = `DMAWC_IO_BASE_CLKS + 4'(iw) - 4'h1;
    end else begin
      cyc_last = `DMAWC_MEM_BASE_CLKS + 4'(mw) - 4'h1;
    end
  endfunction

  function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a,
                                                  input logic [1:0] m);
    case (m)
      `DMAWC_AM_INC: addr_step = ADDR_W'(a + 1'b1);
      `DMAWC_AM_DEC: addr_step = ADDR_W'(a - 1'b1);
      default: addr_step = a;
    endcase
  endfunction

  // ----------------------------------------
  // Job setup
  // ----------------------------------------
  dmawc_state_t st_ff;
  logic job_ch_ff;
  logic [1:0] src_mode_ff;
  logic [1:0] dst_mode_ff;
  logic [1:0] req_sel_ff;
  logic [ADDR_W-1:0] src_ff;
  logic [ADDR_W-1:0] dst_ff;
  logic [COUNT_W-1:0] count_ff;
  logic paced;
  logic burst;
  logic reserved;
  logic take;
  logic [1:0] nxt_src_mode;
  logic [1:0] nxt_dst_mode;

  assign reserved = !START_CH && c0_dst[1] && c0_src[1];
  assign take = START && (st_ff == ST_IDLE) && !reserved;
  assign paced = job_ch_ff || (src_mode_ff == `DMAWC_AM_IO) ||
    (dst_mode_ff == `DMAWC_AM_IO);
  assign burst = ch0_mode_ff[`DMAWC_BURST_SELECT];

  always_comb begin
    if (!START_CH) begin
      nxt_src_mode = c0_src;
      nxt_dst_mode = c0_dst;
    end else if (!wait_ctrl_ff[`DMAWC_CH1_MODE_HI]) begin
      nxt_src_mode = wait_ctrl_ff[`DMAWC_CH1_MODE_LO] ? `DMAWC_AM_DEC : `DMAWC_AM_INC;
      nxt_dst_mode = `DMAWC_AM_IO;
    end else begin
      nxt_src_mode = `DMAWC_AM_IO;
      nxt_dst_mode = wait_ctrl_ff[`DMAWC_CH1_MODE_LO] ? `DMAWC_AM_DEC : `DMAWC_AM_INC;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      err_ff <= 1'b0;
    end else if (START && (st_ff == ST_IDLE)) begin
      err_ff <= reserved;
    end
  end

  // ----------------------------------------
  // Request pacing
  // ----------------------------------------
  logic c0_line;
  logic c0_prev_ff;
  logic c1_prev_ff;
  logic c0_pend_ff;
  logic c1_pend_ff;
  logic req_ok;
  logic req_take;

  always_comb begin
    if (dst_mode_ff != `DMAWC_AM_IO) begin
      c0_line = EXT_REQUEST_CH0;
    end else begin
      case (req_sel_ff)
        `DMAWC_RQ_EXT: c0_line = EXT_REQUEST_CH0;
        `DMAWC_RQ_SER0: c0_line = SERIAL0_TX_REQUEST;
        `DMAWC_RQ_SER1: c0_line = SERIAL1_TX_REQUEST;
        default: c0_line = 1'b0;
      endcase
    end
  end

  always_comb begin
    if (job_ch_ff) begin
      req_ok = ch1_edge ? c1_pend_ff : EXT_REQUEST_CH1;
    end else begin
      req_ok = ch0_edge ? c0_pend_ff : c0_line;
    end
  end
  assign req_take = (st_ff == ST_WAIT_REQ) && req_ok;

  // New edge wins over the clear of the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      c0_prev_ff <= 1'b0;
      c1_prev_ff <= 1'b0;
      c0_pend_ff <= 1'b0;
      c1_pend_ff <= 1'b0;
    end else begin
      c0_prev_ff <= c0_line;
      c1_prev_ff <= EXT_REQUEST_CH1;
      if (c0_line && !c0_prev_ff) begin
        c0_pend_ff <= 1'b1;
      end else if (req_take && !job_ch_ff) begin
        c0_pend_ff <= 1'b0;
      end
      if (EXT_REQUEST_CH1 && !c1_prev_ff) begin
        c1_pend_ff <= 1'b1;
      end else if (req_take && job_ch_ff) begin
        c1_pend_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Data buffer
  // ----------------------------------------
  logic [3:0] cnt_ff;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic rd_end;
  logic wr_end;

  assign rd_end = (st_ff == ST_READ) && (cnt_ff == 4'h0) && BUS_READY && fifo_in_ready;
  assign wr_end = (st_ff == ST_WRITE) && (cnt_ff == 4'h0) && BUS_READY && fifo_out_valid;

  dmawc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RST_N(RST_N),
    .in_valid(rd_end),
    .in_ready(fifo_in_ready),
    .in_data(RD_DATA),
    .out_valid(fifo_out_valid),
    .out_ready(wr_end),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  logic src_io;
  logic dst_io;
  assign src_io = (src_mode_ff == `DMAWC_AM_IO);
  assign dst_io = (dst_mode_ff == `DMAWC_AM_IO);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      job_ch_ff <= 1'b0;
      src_mode_ff <= `DMAWC_AM_INC;
      dst_mode_ff <= `DMAWC_AM_INC;
      req_sel_ff <= `DMAWC_RQ_EXT;
      src_ff <= '0;
      dst_ff <= '0;
      count_ff <= '0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (take && (START_COUNT != '0)) begin
            job_ch_ff <= START_CH;
            src_mode_ff <= nxt_src_mode;
            dst_mode_ff <= nxt_dst_mode;
            req_sel_ff <= START_DST[`DMAWC_BANK_SEL_HI:`DMAWC_BANK_SEL_LO];
            // Ch1 I/O-to-memory reads the I/O address and writes memory
            if (START_CH && wait_ctrl_ff[`DMAWC_CH1_MODE_HI]) begin
              src_ff <= START_DST;
              dst_ff <= START_SRC;
            end else begin
              src_ff <= START_SRC;
              dst_ff <= START_DST;
            end
            count_ff <= START_COUNT;
            st_ff <= ST_WAIT_REQ;
          end
        end
        ST_WAIT_REQ: begin
          if (!paced || req_ok) begin
            cnt_ff <= cyc_last(src_io, mem_waits, io_waits);
            st_ff <= ST_READ;
          end
        end
        ST_READ: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (rd_end) begin
            cnt_ff <= cyc_last(dst_io, mem_waits, io_waits);
            st_ff <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (wr_end) begin
            count_ff <= count_ff - 1'b1;
            src_ff <= addr_step(src_ff, src_mode_ff);
            dst_ff <= addr_step(dst_ff, dst_mode_ff);
            if (count_ff == COUNT_W'(1)) begin
              st_ff <= ST_IDLE;
            end else if (paced) begin
              st_ff <= ST_WAIT_REQ;
            end else if (burst) begin
              cnt_ff <= cyc_last(src_io, mem_waits, io_waits);
              st_ff <= ST_READ;
            end else begin
              cnt_ff <= `DMAWC_STEAL_CLKS - 4'h1;
              st_ff <= ST_STEAL;
            end
          end
        end
        ST_STEAL: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else begin
            cnt_ff <= cyc_last(src_io, mem_waits, io_waits);
            st_ff <= ST_READ;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Bus outputs
  // ----------------------------------------
  assign CYC_ACTIVE = (st_ff == ST_READ) || (st_ff == ST_WRITE);
  assign BUS_HOLD = CYC_ACTIVE;
  assign CYC_WRITE = (st_ff == ST_WRITE);
  assign CYC_IO = CYC_WRITE ? dst_io : src_io;
  assign CYC_ADDR = CYC_WRITE ? dst_ff : src_ff;
  assign CYC_WDATA = fifo_out_data;
  assign CYC_DONE = rd_end || wr_end;
  assign BUSY = (st_ff != ST_IDLE);
  assign MODE_ERR = err_ff;
  assign BYTES_LEFT = count_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reserved_refused: assert property (@(posedge CLK) disable iff (!RST_N)
    (START && !START_CH && (st_ff == ST_IDLE) && reserved) |=> (MODE_ERR && !BUSY))
    else $error("reserved channel 0 mode was started");

  a_mode_readback: assert property (@(posedge CLK) disable iff (!RST_N)
    (IO_WR && (IO_ADDR == `DMAWC_ADDR_CH0_MODE)) ##1
    (IO_RD && !IO_WR && (IO_ADDR == `DMAWC_ADDR_CH0_MODE))
    |=> (IO_RDATA == ($past(IO_WDATA, 2) & `DMAWC_CH0_MODE_MASK)))
    else $error("mode register readback mismatch");

  a_burst_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_end && burst && !paced && (count_ff > COUNT_W'(1))) |=> (BUS_HOLD && !CYC_WRITE))
    else $error("burst released the bus early");

  a_steal_gap: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_end && !burst && !paced && (count_ff > COUNT_W'(1)))
    |=> (!BUS_HOLD [*3]) ##1 BUS_HOLD)
    else $error("cycle steal gap wrong");

  a_paced_wait: assert property (@(posedge CLK) disable iff (!RST_N)
    ((st_ff == ST_WAIT_REQ) && paced && !req_ok) |=> (st_ff == ST_WAIT_REQ))
    else $error("paced byte started without request");

  a_mem_waits: assert property (@(posedge CLK) disable iff (!RST_N)
    (CYC_ACTIVE && $changed(st_ff) && !CYC_IO && (mem_waits == 2'h3))
    |-> (!CYC_DONE [*5]))
    else $error("memory cycle shorter than six clocks");

  a_io_waits: assert property (@(posedge CLK) disable iff (!RST_N)
    (CYC_ACTIVE && $changed(st_ff) && CYC_IO && (io_waits == 3'h4))
    |-> (!CYC_DONE [*6]))
    else $error("I/O cycle shorter than seven clocks");

  a_read_write: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_end |=> (CYC_WRITE && (CYC_ADDR == dst_ff)))
    else $error("read not followed by write");

  a_count_step: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_end |=> ((count_ff == COUNT_W'($past(count_ff) - 1'b1)) &&
    (src_ff == addr_step($past(src_ff), src_mode_ff))))
    else $error("count or address not updated");

endmodule

//--- verif/dmawc_periph.sv
// Memory and I/O peripheral model on the far side of the DMA bus.
// Assumes the engine's cycle strobes, one clock and an active-low reset.
`timescale 1ns/100ps
module dmawc_periph (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Engine bus cycle
  input wire logic cyc_active,
  input wire logic cyc_write,
  input wire logic [19:0] cyc_addr,
  input wire logic cyc_done,
  // Answer
  input wire logic [3:0] stall,
  output logic bus_ready,
  output logic [7:0] rd_data
);
  logic [3:0] cnt_ff;
  logic [7:0] idle_ff;

  // Slow answers keep ready low for the first stall clocks of a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 4'h0;
    else if (!cyc_active || cyc_done) cnt_ff <= 4'h0;
    else if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
  end

  // A released data bus must not look like the last byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idle_ff <= 8'h00;
    else idle_ff <= ~idle_ff;
  end

  assign bus_ready = !(cyc_active && cnt_ff < stall);
  assign rd_data = (cyc_active && !cyc_write) ? (cyc_addr[7:0] ^ 8'h5A) : idle_ff;
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the DMA mode and wait control block.
// Assumes the design under core/ and the peripheral model in verif/.
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_n, io_wr, io_rd, start, start_ch, ext0, ser0, ser1, ext1;
  logic [7:0] io_addr, io_wdata, io_rdata, rd_data, cyc_wdata;
  logic [19:0] start_src, start_dst, cyc_addr;
  logic [15:0] start_count, bytes_left;
  logic bus_hold, cyc_active, cyc_write, cyc_io, cyc_done, bus_ready, busy, mode_err;
  logic [1:0] mem_ws, pace_sel;
  logic [2:0] io_ws;
  logic [3:0] stall;
  logic hold_q;
  int n_errors, cmp_count, gaps, len, io_x, burst;
  logic [35:0] recs[$];

  always #2.5 clk = ~clk;

  dmawc_top dut (.CLK(clk), .RST_N(rst_n), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .START(start), .START_CH(start_ch),
    .START_SRC(start_src), .START_DST(start_dst), .START_COUNT(start_count),
    .EXT_REQUEST_CH0(ext0), .SERIAL0_TX_REQUEST(ser0), .SERIAL1_TX_REQUEST(ser1),
    .EXT_REQUEST_CH1(ext1), .BUS_HOLD(bus_hold), .CYC_ACTIVE(cyc_active),
    .CYC_WRITE(cyc_write), .CYC_IO(cyc_io), .CYC_ADDR(cyc_addr), .CYC_WDATA(cyc_wdata),
    .CYC_DONE(cyc_done), .BUS_READY(bus_ready), .RD_DATA(rd_data), .BUSY(busy),
    .MODE_ERR(mode_err), .BYTES_LEFT(bytes_left), .MEM_WAIT_STATES(mem_ws),
    .IO_WAIT_STATES(io_ws));

  dmawc_periph periph (.clk(clk), .rst_n(rst_n), .cyc_active(cyc_active),
    .cyc_write(cyc_write), .cyc_addr(cyc_addr), .cyc_done(cyc_done), .stall(stall),
    .bus_ready(bus_ready), .rd_data(rd_data));

  // ------
  // Bus monitor: one record per finished cycle, plus bus give-backs
  // ------
  always @(posedge clk) begin
    if (cyc_active && cyc_done) begin
      recs.push_back({cyc_write, cyc_io, 6'(len + 1), cyc_write ? cyc_wdata : rd_data, cyc_addr});
      len = 0;
    end else if (cyc_active) len = len + 1;
    else len = 0;
    if (hold_q && !bus_hold && busy) gaps = gaps + 1;
    hold_q = bus_hold;
  end

  // Request pulses far apart, so one pulse paces one byte
  always begin
    @(posedge clk);
    if (pace_sel != 2'h0) begin
      #1;
      {ext1, ser0, ext0} = 3'h1 << (pace_sel - 2'h1);
      repeat (2) @(posedge clk);
      #1;
      {ext1, ser0, ext0} = 3'h0;
      repeat (20) @(posedge clk);
    end
  end

  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    check("register read", 36'(exp), 36'(io_rdata));
  endtask

  task automatic pulse_start(input logic ch, input logic [19:0] src, input logic [19:0] dst);
    start_ch = ch;
    start_src = src;
    start_dst = dst;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
  endtask

  function automatic int step_of(input int code);
    return code == 0 ? 1 : code == 1 ? -1 : 0;
  endfunction

  function automatic int clen(input int base);
    return base > int'(stall) ? base : int'(stall) + 1;
  endfunction

  task automatic run_job(input logic ch, input logic [19:0] src, input logic [19:0] dst,
      input logic [19:0] rb, input int rs, input logic [19:0] wb, input int ws,
      input logic sio, input logic dio, input int rlen, input int wlen, input int ngap);
    logic [19:0] ra;
    logic [7:0] d;
    recs.delete();
    gaps = 0;
    pulse_start(ch, src, dst);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
    #1;
    check("busy", 36'h0, 36'(busy));
    check("bytes left", 36'h0, 36'(bytes_left));
    check("bus give-backs", 36'(ngap), 36'(gaps));
    check("cycle count", 36'h4, 36'(recs.size()));
    if (recs.size() == 4) begin
      for (int i = 0; i < 2; i++) begin
        ra = rb + 20'(i * rs);
        d = ra[7:0] ^ 8'h5A;
        check("read", {1'b0, sio, 6'(rlen), d, ra}, recs[2 * i]);
        check("write", {1'b1, dio, 6'(wlen), d, wb + 20'(i * ws)}, recs[2 * i + 1]);
      end
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #150000;
    n_errors++;
    stop_test();
  end

  // ------
  // Tests
  // ------
  initial begin
    {clk, rst_n, io_wr, io_rd, start, start_ch, ext0, ser0, ser1, ext1} = 10'h0;
    {io_addr, io_wdata, start_src, start_dst, stall, pace_sel, hold_q} = 63'h0;
    start_count = 16'h0002;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd_chk(8'h31, 8'h00);
    // Same strobe twice in a row: let an edge pass between
    @(posedge clk);
    #1;
    rd_chk(8'h32, 8'hF0);
    check("mem waits", 36'h3, 36'(mem_ws));
    check("io waits", 36'h4, 36'(io_ws));
    wr_reg(8'h31, 8'hFF);
    rd_chk(8'h31, 8'h3E);
    @(posedge clk);
    #1;
    rd_chk(8'h36, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h32, 8'(c * 8'h50));
      @(posedge clk);
      #1;
      check("mem waits", 36'(c), 36'(mem_ws));
      check("io waits", 36'(c + 1), 36'(io_ws));
    end
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h31, 8'h28 | 8'(m % 2 * 4) | 8'(m / 2 * 16));
      pulse_start(1'b0, 20'h00080, 20'h00100);
      check("mode error", 36'h1, 36'(mode_err));
      check("busy", 36'h0, 36'(busy));
    end
    $display("reserved mode test done");
    for (int dm = 0; dm < 4; dm++) begin
      for (int sm = 0; sm < 4; sm++) begin
        if (dm >= 2 && sm >= 2) continue;
        io_x = int'(dm == 3 || sm == 3);
        burst = dm % 2;
        wr_reg(8'h31, 8'(dm * 16 + sm * 4 + burst * 2));
        @(posedge clk);
        #1;
        wr_reg(8'h32, dm == 3 ? 8'h88 : 8'h80);
        stall = (dm == sm) ? 4'h5 : 4'h0;
        pace_sel = io_x == 0 ? 2'h0 : (dm == 3) ? 2'h2 : 2'h1;
        run_job(1'b0, 20'h00080, 20'h10040, 20'h00080, step_of(sm), 20'h10040, step_of(dm),
          sm == 3, dm == 3, clen(sm == 3 ? 4 : 5), clen(dm == 3 ? 4 : 5),
          (io_x != 0 || burst == 0) ? 1 : 0);
        pace_sel = 2'h0;
      end
    end
    $display("channel 0 test done");
    stall = 4'h0;
    for (int m = 0; m < 4; m++) begin
      // Three memory waits, four I/O waits; edge sense only for the decrementing memory-to-I/O job
      wr_reg(8'h32, 8'hF0 | 8'(m) | (m == 1 ? 8'h04 : 8'h00));
      pace_sel = 2'h3;
      if (m < 2) run_job(1'b1, 20'h00200, 20'h00055, 20'h00200, step_of(m), 20'h00055, 0,
        1'b0, 1'b1, 6, 7, 1);
      else run_job(1'b1, 20'h00200, 20'h00055, 20'h00055, 0, 20'h00200, step_of(m - 2),
        1'b1, 1'b0, 7, 6, 1);
      pace_sel = 2'h0;
    end
    $display("channel 1 test done");
    stop_test();
  end
endmodule
